// >>> rtl/sstb_slave.sv
`timescale 1ns/1ps
module sstb_slave
(
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    // spi pins
    input  wire logic                   sck,
    input  wire logic                   selectN,
    input  wire logic                   mosi,
    output logic                        misoOut,
    output logic                        misoOe,
    input  wire logic                   misoDirOut,
    // configuration
    input  wire sstb_pkg::sstb_cfg_s    cfg,
    input  wire sstb_pkg::sstb_irq_s    irqEnable,
    input  wire logic                   deepSleep,
    // software data port
    input  wire logic                   dataWr,
    input  wire logic [7:0]             dataWrValue,
    input  wire logic                   dataRd,
    output logic [7:0]                  dataRdValue,
    output logic                        rxValid,
    // flags
    input  wire sstb_pkg::sstb_irq_s    flagClear,
    input  wire logic                   collisionClear,
    input  wire logic                   overflowClear,
    output sstb_pkg::sstb_irq_s         flags,
    output logic                        write_collision_flag,
    output logic                        receive_overflow_flag,
    output logic                        irqReq
);
    import sstb_pkg::*;

    logic [2:0]  syncPins;
    logic        sckS;
    logic        selNS;
    logic        mosiS;
    logic        sckPrev_ff;
    logic        selPrev_ff;
    logic        sckRise;
    logic        sckFall;
    logic        sampleEdge;
    logic        setupEdge;
    logic        active;
    sstb_state_e state_ff;
    logic [3:0]  bitCnt_ff;
    logic [7:0]  shift_ff;
    logic [7:0]  rxShift_ff;
    logic [7:0]  txBuf_ff;
    logic        txBufFull_ff;
    logic        byteDone;
    logic        directLoad;
    logic        directLoadPend_ff;
    logic        txPend_ff;
    logic        txcRise_ff;
    logic [7:0]  rxByte;
    logic        emptyRise_ff;
    logic        rxcRise_ff;
    logic        sentAll;
    logic [7:0]  rxq_ff [SSTB_RXQ_DEPTH];
    logic [1:0]  rxCount_ff;
    logic        wrCollide;

    // ****************************************
    // pin sampling and edges
    // ****************************************
    sstb_sync #(.WIDTH(3)) u_sync
    (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .asyncIn ({sck, ~selectN, mosi}), // select inverted so reset reads as deselected
        .syncOut (syncPins)
    );

    assign sckS  = syncPins[2];
    assign selNS = ~syncPins[1];
    assign mosiS = syncPins[0];

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sckPrev_ff <= 1'b0;
            selPrev_ff <= 1'b1;
        end
        else
        begin
            sckPrev_ff <= sckS;
            selPrev_ff <= selNS;
        end
    end

    assign sckRise = sckS & ~sckPrev_ff;
    assign sckFall = ~sckS & sckPrev_ff;
    // leading edge rises in modes 0/1, falls in 2/3; odd modes sample trailing [R15] [R16] [R20]
    assign sampleEdge = (cfg.transferMode[1] ^ cfg.transferMode[0]) ? sckFall : sckRise;
    assign setupEdge  = (cfg.transferMode[1] ^ cfg.transferMode[0]) ? sckRise : sckFall;
    assign active     = ~selNS & ~deepSleep; // [R19]

    function automatic logic outBit(input logic [7:0] v, input logic lsbFirst);
        outBit = lsbFirst ? v[0] : v[7]; // [R23]
    endfunction

    function automatic logic [7:0] withBit(input logic [7:0] v, input logic b,
                                           input logic lsbFirst);
        withBit = lsbFirst ? {b, v[7:1]} : {v[6:0], b}; // [R23]
    endfunction

    assign rxByte = withBit(rxShift_ff, mosiS, cfg.bitOrderSelect);

    // ****************************************
    // transfer state machine
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff  <= SSTB_IDLE;
            bitCnt_ff <= SSTB_CNT_RST;
        end
        else if (!active)
        begin
            state_ff  <= SSTB_IDLE; // [R01] [R02] [R19]
            bitCnt_ff <= SSTB_CNT_RST;
        end
        else
        begin
            unique case (state_ff)
                SSTB_IDLE:
                begin
                    if (sampleEdge)
                    begin
                        state_ff  <= SSTB_SHIFT; // [R04]
                        bitCnt_ff <= 4'h1;
                    end
                end
                SSTB_SHIFT:
                begin
                    if (sampleEdge)
                    begin
                        if (bitCnt_ff == 4'(SSTB_BITS - 1))
                        begin
                            state_ff  <= SSTB_DONE; // [R24]
                            bitCnt_ff <= SSTB_CNT_RST;
                        end
                        else
                        begin
                            bitCnt_ff <= bitCnt_ff + 4'h1;
                        end
                    end
                end
                SSTB_DONE:
                begin
                    state_ff <= SSTB_IDLE;
                end
            endcase
        end
    end

    assign byteDone = active & (state_ff == SSTB_SHIFT) & sampleEdge
                      & (bitCnt_ff == 4'(SSTB_BITS - 1));

    // ****************************************
    // receive shifter
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rxShift_ff <= SSTB_BYTE_RST;
        end
        else if (active && sampleEdge)
        begin
            rxShift_ff <= rxByte; // [R23]
        end
    end

    // ****************************************
    // transmit shifter and buffer
    // ****************************************
    assign directLoad = dataWr & selNS & cfg.bufferModeEnable & cfg.bufferWaitReceive
                        & ~txBufFull_ff & (state_ff == SSTB_IDLE) & ~emptyRise_ff
                        & ~txPend_ff;
    assign wrCollide  = dataWr & ~cfg.bufferModeEnable & (state_ff != SSTB_IDLE);

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            shift_ff     <= SSTB_BYTE_RST;
            txBuf_ff     <= SSTB_BYTE_RST;
            txBufFull_ff <= 1'b0;
            txPend_ff    <= 1'b0;
        end
        else if (byteDone)
        begin
            // received byte stays as dummy unless buffer refills it [R08] [R09]
            if (cfg.bufferModeEnable && txBufFull_ff)
            begin
                shift_ff     <= txBuf_ff;
                txBufFull_ff <= 1'b0; // [R11]
                txPend_ff    <= 1'b1; // [R13]
            end
            else
            begin
                shift_ff  <= rxByte;
                txPend_ff <= 1'b0; // [R13]
            end
        end
        else if (!active)
        begin
            shift_ff <= shift_ff; // partial transmit discarded, shifted remainder kept [R02]
            if (cfg.bufferModeEnable && txBufFull_ff && selNS && cfg.bufferWaitReceive
                && (selPrev_ff == 1'b1) && directLoadPend_ff)
            begin
                shift_ff     <= txBuf_ff; // [R14]
                txBufFull_ff <= 1'b0;
                txPend_ff    <= 1'b1;
            end
            else if (dataWr && !cfg.bufferModeEnable)
            begin
                shift_ff <= dataWrValue; // [R03]
            end
            else if (dataWr && cfg.bufferModeEnable && !txBufFull_ff)
            begin
                txBuf_ff     <= dataWrValue; // [R07] [R11]
                txBufFull_ff <= 1'b1;
            end
        end
        else if (active && setupEdge && state_ff == SSTB_SHIFT)
        begin
            shift_ff <= withBit(shift_ff, 1'b0, cfg.bitOrderSelect);
        end
        else if (dataWr && cfg.bufferModeEnable && !txBufFull_ff)
        begin
            txBuf_ff     <= dataWrValue; // [R10] [R11]
            txBufFull_ff <= 1'b1;
        end
        else if (dataWr && !cfg.bufferModeEnable && state_ff == SSTB_IDLE)
        begin
            shift_ff <= dataWrValue;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            directLoadPend_ff <= 1'b0;
        end
        else
        begin
            directLoadPend_ff <= directLoad; // [R14]
        end
    end

    // released when deselected [R21]
    assign misoOe  = misoDirOut & ~selNS;
    assign misoOut = outBit(shift_ff, cfg.bitOrderSelect);

    // ****************************************
    // receive queue
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rxq_ff[0]  <= SSTB_BYTE_RST;
            rxq_ff[1]  <= SSTB_BYTE_RST;
            rxCount_ff <= 2'h0;
            receive_overflow_flag <= 1'b0;
        end
        else
        begin
            if (byteDone)
            begin
                if (rxCount_ff == 2'h0 || (dataRd && rxCount_ff == 2'h1))
                begin
                    rxq_ff[0]  <= rxByte; // [R24]
                    rxCount_ff <= 2'h1;
                end
                else if (cfg.bufferModeEnable && rxCount_ff == 2'h1)
                begin
                    rxq_ff[1]  <= rxByte; // [R25]
                    rxCount_ff <= 2'h2;
                end
                else if (dataRd)
                begin
                    rxq_ff[0] <= rxq_ff[1];
                    rxq_ff[1] <= rxByte;
                end
                else if (cfg.bufferModeEnable)
                begin
                    receive_overflow_flag <= 1'b1; // new byte dropped, queue kept [R25]
                end
                else
                begin
                    rxq_ff[0] <= rxByte;
                end
            end
            else if (dataRd && rxCount_ff != 2'h0)
            begin
                rxq_ff[0]  <= rxq_ff[1];
                rxCount_ff <= rxCount_ff - 2'h1;
            end
            if (overflowClear && !(byteDone && rxCount_ff == 2'h2 && !dataRd))
            begin
                receive_overflow_flag <= 1'b0;
            end
        end
    end

    assign dataRdValue = rxq_ff[0];
    assign rxValid     = rxCount_ff != 2'h0;

    // ****************************************
    // flags
    // ****************************************
    assign sentAll = ~txBufFull_ff & ~txPend_ff;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            emptyRise_ff <= 1'b0;
            rxcRise_ff   <= 1'b0;
            txcRise_ff   <= 1'b0;
        end
        else
        begin
            emptyRise_ff <= byteDone;
            rxcRise_ff   <= emptyRise_ff;
            txcRise_ff   <= rxcRise_ff;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            flags                <= '0;
            write_collision_flag <= 1'b0;
        end
        else
        begin
            // set wins over clear on every flag except bufferEmpty, which follows ~txBufFull_ff in buffer mode (0 otherwise) and ignores its clear
            flags.selectTrigger <= (flags.selectTrigger & ~flagClear.selectTrigger)
                                   | (cfg.bufferModeEnable & selPrev_ff & ~selNS);
            flags.bufferEmpty <= cfg.bufferModeEnable ? (~txBufFull_ff) : 1'b0; // [R11]
            flags.receiveComplete <= (flags.receiveComplete & ~flagClear.receiveComplete)
                                     | (cfg.bufferModeEnable ? rxcRise_ff : byteDone);
            // [R05] [R12]
            flags.transferComplete <= (flags.transferComplete & ~flagClear.transferComplete)
                                      | (cfg.bufferModeEnable & txcRise_ff & sentAll);
            // [R13]
            write_collision_flag <= (write_collision_flag & ~collisionClear) | wrCollide; // [R06]
        end
    end

    // single request for all sources [R17] [R18]
    assign irqReq = |(flags & irqEnable);

    // ****************************************
    // checks
    // ****************************************
    rx_after_done_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R12]
        byteDone && cfg.bufferModeEnable |=> ##2 flags.receiveComplete)
        else $error("receive flag late");
    tx_after_rx_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R13]
        $rose(flags.transferComplete) |-> $past(flags.receiveComplete))
        else $error("transfer flag before receive flag");
    deselect_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R01]
        selNS |=> state_ff == SSTB_IDLE && bitCnt_ff == SSTB_CNT_RST)
        else $error("not idle when deselected");
    miso_release_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R21]
        selNS |-> !misoOe)
        else $error("miso driven while deselected");
    irq_level_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R18]
        (flags.receiveComplete && irqEnable.receiveComplete) |-> irqReq)
        else $error("request missing");
    collision_set_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R06]
        wrCollide |=> write_collision_flag)
        else $error("collision flag missing");
    buffer_keep_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R10]
        dataWr && txBufFull_ff |=> $stable(txBuf_ff))
        else $error("full buffer overwritten");
endmodule

// >>> rtl/sstb_pkg.sv
// How it works
// R01: select high resets state machine and counter
// R02: select rising mid-byte drops both partial bytes
// R03: unbuffered, select high: idle, data loadable
// R04: select low: drive loaded byte from first edge
// R05: unbuffered: done flag after full byte
// R06: unbuffered early write dropped, collision flag set
// R07: buffer enable adds buffer, queue and flags
// R08: no-wait buffered: first byte is a dummy
// R09: buffer loads shifter only after transfer ends
// R10: write into full buffer is lost
// R11: empty flag clears on write, sets on copy
// R12: receive flag one cycle after empty flag
// R13: transfer flag one cycle after receive flag
// R14: wait-receive: idle write goes to shifter next cycle
// R15: two-bit mode field picks polarity and phase
// R16: change on one edge, sample on other
// R17: one request line for four sources
// R18: request while flag and enable both set
// R19: runs in idle sleep, deeper sleep aborts
// R20: mode 0 idle low, 2 idle high, odd trailing
// R21: output released while select high
// R22: master keeps each clock phase over two cycles
// R23: order bit 0 msb first, 1 lsb first
// R24: eight bits per transfer, byte readable after
// R25: buffered two-entry queue, overflow flag
package sstb_pkg;

    // ****************************************
    // constants
    // ****************************************
    localparam int          SSTB_BITS      = 8;
    localparam logic [3:0]  SSTB_CNT_RST   = 4'h0;
    localparam logic [7:0]  SSTB_BYTE_RST  = 8'h00;
    localparam int          SSTB_RXQ_DEPTH = 2;
    localparam int          SSTB_SYNC_LEN  = 2;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic       bufferModeEnable;
        logic       bufferWaitReceive;
        logic       bitOrderSelect;
        logic [1:0] transferMode;
    } sstb_cfg_s;

    typedef struct packed {
        logic selectTrigger;
        logic bufferEmpty;
        logic transferComplete;
        logic receiveComplete;
    } sstb_irq_s;

    typedef enum logic [1:0] {
        SSTB_IDLE,
        SSTB_SHIFT,
        SSTB_DONE
    } sstb_state_e;

endpackage

// >>> rtl/sstb_sync.sv
`timescale 1ns/1ps
module sstb_sync
#(
    parameter int WIDTH = 3
)
(
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    // data
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    import sstb_pkg::*;

    logic [WIDTH-1:0] stage1_ff;

    // ****************************************
    // two-flop synchroniser
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stage1_ff <= '0;
            syncOut   <= '0;
        end
        else
        begin
            stage1_ff <= asyncIn;
            syncOut   <= stage1_ff;
        end
    end
endmodule

// >>> dv/sstb_master.sv
`timescale 1ns/1ps
module sstb_master
(
    // spi pins
    output logic      sck,
    output logic      selectN,
    output logic      mosi,
    input  wire logic misoOut,
    input  wire logic misoOe
);
    logic [1:0] mode;
    logic       lsbFirst;

    initial
    begin
        mode = 2'h0;
        lsbFirst = 1'b0;
        sck = 1'b0;
        selectN = 1'b1;
        mosi = 1'b0;
    end

    // ****************************************
    // one framed transfer of nb bits
    // ****************************************
    // each clock phase lasts 100 ns, four ref_clk cycles
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        int i;
        int k;
        rx = 8'h00;
        sck = mode[1]; // idle level set while deselected
        #37 selectN = 1'b0;
        #100;
        for (i = 0; i < nb; i++)
        begin
            k = lsbFirst ? i : 7 - i;
            if (!mode[0])
                mosi = tx[k];
            #100 sck = ~sck;
            if (mode[0])
                mosi = tx[k]; // change on leading, sample on trailing
            else
                rx[k] = misoOe ? misoOut : 1'bx;
            #100 sck = ~sck;
            if (mode[0])
                rx[k] = misoOe ? misoOut : 1'bx;
        end
        #100 selectN = 1'b1;
        mosi = ~mosi; // released line shows no stale bit
    endtask
endmodule

// >>> dv/test_spi_slave_transfer_buffering.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module test_spi_slave_transfer_buffering;
    import sstb_pkg::*;
    logic       ref_clk;
    logic       rstn;
    logic       sck;
    logic       selectN;
    logic       mosi;
    logic       misoOut;
    logic       misoOe;
    logic       deepSleep;
    logic       dataWr;
    logic [7:0] dataWrValue;
    logic       dataRd;
    logic [7:0] dataRdValue;
    logic       rxValid;
    logic       collisionClear;
    logic       overflowClear;
    logic       write_collision_flag;
    logic       receive_overflow_flag;
    logic       irqReq;
    logic [7:0] got;
    logic [3:0] m;
    sstb_cfg_s  cfg;
    sstb_irq_s  irqEnable;
    sstb_irq_s  flagClear;
    sstb_irq_s  flags;
    int         n_mismatch;
    int         comparisons;

    initial
        ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;

    sstb_master u_sstb_master (.sck, .selectN, .mosi, .misoOut, .misoOe);

    sstb_slave u_sstb_slave (.ref_clk, .rstn, .sck, .selectN, .mosi, .misoOut, .misoOe,
        .misoDirOut(1'b1), .cfg, .irqEnable, .deepSleep, .dataWr, .dataWrValue, .dataRd,
        .dataRdValue, .rxValid, .flagClear, .collisionClear, .overflowClear, .flags,
        .write_collision_flag, .receive_overflow_flag, .irqReq);

    // ****************************************
    // access tasks
    // ****************************************
    task automatic wr(input logic [7:0] v);
        @(posedge ref_clk);
        dataWr <= 1'b1;
        dataWrValue <= v;
        @(posedge ref_clk);
        dataWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] e);
        @(negedge ref_clk);
        `CHK("rxValid", 1'b1, rxValid)
        `CHK("dataRdValue", e, dataRdValue)
        @(posedge ref_clk);
        dataRd <= 1'b1;
        @(posedge ref_clk);
        dataRd <= 1'b0;
    endtask

    task automatic clr();
        @(posedge ref_clk);
        flagClear <= 4'hf;
        collisionClear <= 1'b1;
        overflowClear <= 1'b1;
        dataRd <= 1'b1;
        @(posedge ref_clk);
        flagClear <= 4'h0;
        collisionClear <= 1'b0;
        overflowClear <= 1'b0;
        repeat (3) @(posedge ref_clk);
        dataRd <= 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic xfer(input logic [7:0] tx, input int nb, input logic [7:0] e);
        u_sstb_master.xfer(tx, nb, got);
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        if (nb == 8)
            `CHK("miso byte", e, got)
    endtask

    task automatic stop_test();
        if (n_mismatch == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        {rstn, dataWr, dataRd, deepSleep, collisionClear, overflowClear} = '0;
        dataWrValue = 8'h00;
        cfg = '0;
        irqEnable = 4'h1;
        flagClear = '0;
        n_mismatch = 0;
        comparisons = 0;
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(negedge ref_clk);
        `CHK("misoOe", 1'b0, misoOe)
        `CHK("flags", 4'h0, flags)
        for (m = 4'h0; m < 4'h8; m++)
        begin
            cfg <= '{1'b0, 1'b0, m[2], m[1:0]};
            u_sstb_master.mode = m[1:0];
            u_sstb_master.lsbFirst = m[2];
            wr({4'h3, m});
            xfer({4'hc, m}, 8, {4'h3, m});
            `CHK("rx flag", 1'b1, flags.receiveComplete)
            `CHK("irqReq", 1'b1, irqReq)
            rd({4'hc, m});
            clr();
            `CHK("irqReq", 1'b0, irqReq)
        end
        cfg <= '0;
        u_sstb_master.mode = 2'h0;
        u_sstb_master.lsbFirst = 1'b0;
        wr(8'h69);
        fork
            xfer(8'h96, 8, 8'h69);
            begin
                #1500;
                wr(8'h5a);
            end
        join
        `CHK("collision", 1'b1, write_collision_flag)
        rd(8'h96);
        clr();
        cfg <= '{1'b1, 1'b0, 1'b0, 2'h0};
        wr(8'h43);
        repeat (2) @(negedge ref_clk);
        `CHK("buffer empty", 1'b0, flags.bufferEmpty)
        xfer(8'h01, 8, 8'h96);
        `CHK("buffer empty", 1'b1, flags.bufferEmpty)
        wr(8'h44);
        wr(8'h45);
        xfer(8'h02, 8, 8'h43);
        `CHK("tx done early", 1'b0, flags.transferComplete)
        xfer(8'h03, 8, 8'h44);
        `CHK("tx done", 1'b1, flags.transferComplete)
        `CHK("overflow", 1'b1, receive_overflow_flag)
        rd(8'h01);
        clr();
        cfg <= '{1'b1, 1'b1, 1'b0, 2'h0};
        wr(8'h5a);
        wr(8'ha5);
        xfer(8'h11, 8, 8'h5a);
        xfer(8'h22, 8, 8'ha5);
        rd(8'h11);
        rd(8'h22);
        clr();
        cfg <= '0;
        deepSleep <= 1'b1;
        u_sstb_master.xfer(8'h5a, 8, got);
        repeat (8) @(posedge ref_clk);
        deepSleep <= 1'b0;
        @(negedge ref_clk);
        `CHK("rxValid", 1'b0, rxValid)
        xfer(8'hf0, 4, 8'h00);
        `CHK("rxValid", 1'b0, rxValid)
        `CHK("rx flag", 1'b0, flags.receiveComplete)
        wr(8'h3c);
        xfer(8'hc3, 8, 8'h3c);
        rd(8'hc3);
        stop_test();
    end

    initial
    begin
        #500000;
        n_mismatch++;
        stop_test();
    end
endmodule
